// File: core/ext_exec_defs.svh
// Constants for the extended pointer and call instruction executor
`ifndef EXT_EXEC_DEFS_SVH
`define EXT_EXEC_DEFS_SVH

`define EXT_ADDR_W      12
`define EXT_PC_W        21
`define EXT_QCOUNT      4
`define EXT_OP_ADD_PTR  8'hE8
`define EXT_OP_MOVE     9'h1D6
`define EXT_OP_CALL_VIA_WORKING_REGISTER    16'h0014
`define EXT_OP_SECOND   4'hF
`define EXT_SEL_RETURN  2'h3
`define EXT_SEL_FRAME   2'h2
`define EXT_RET_STEP    21'h0_0002
`define EXT_RST_WORD    16'h0000
`define EXT_RST_ADDR    12'h000
`define EXT_RST_PC      21'h0_0000
`define EXT_RST_QPHASE  4'h8

`endif

// File: core/ext_exec_pkg.sv
// Types for the extended pointer and call instruction executor
package ext_exec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_NOP  = 2'b01,
    ST_MOVE = 2'b10
  } exec_state_t;

endpackage

// File: core/extended_pointer_instruction_exec.sv
// Executor for pointer-add, add-and-return, register call and indexed move
`include "ext_exec_defs.svh"

module extended_pointer_instruction_exec
  import ext_exec_pkg::*;
#(
  parameter int               PTR_W        = 12,
  parameter logic [11:0]      PC_LOW_ADDR  = 12'hFF0,
  parameter logic [11:0]      STK_UP_ADDR  = 12'hFF1,
  parameter logic [11:0]      STK_HI_ADDR  = 12'hFF2,
  parameter logic [11:0]      STK_LO_ADDR  = 12'hFF3,
  parameter logic [11:0]      INDIRECT_LO  = 12'hFE0,
  parameter logic [11:0]      INDIRECT_HI  = 12'hFEF
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Configuration
  input  wire logic                 i_ext_enable,
  // Fetch
  input  wire logic                 i_instr_valid,
  input  wire logic [15:0]          i_instr,
  // Core state
  input  wire logic [20:0]          i_pc,
  input  wire logic [20:0]          i_tos,
  input  wire logic [7:0]           i_working_register,
  input  wire logic [7:0]           i_pc_high_latch,
  input  wire logic [4:0]           i_pc_upper_latch,
  input  wire logic [PTR_W-1:0]     i_ptr0,
  input  wire logic [PTR_W-1:0]     i_ptr1,
  input  wire logic [PTR_W-1:0]     i_ptr2,
  // Data memory read return
  input  wire logic [7:0]           i_rd_data,
  // Sequencing status
  output logic                      o_busy,
  output logic                      o_std_pass,
  // Pointer write
  output logic                      o_ptr_we,
  output logic [1:0]                o_ptr_sel,
  output logic [PTR_W-1:0]          o_ptr_val,
  // Return stack and program counter
  output logic                      o_push,
  output logic [20:0]               o_push_val,
  output logic                      o_pop,
  output logic                      o_pc_load,
  output logic [20:0]               o_pc_val,
  // Data memory
  output logic                      o_rd_en,
  output logic [11:0]               o_rd_addr,
  output logic                      o_wr_en,
  output logic [11:0]               o_wr_addr,
  output logic [7:0]                o_wr_data,
  output logic                      o_dest_blocked
);

  if (PTR_W < `EXT_ADDR_W || PTR_W > 16) begin : g_width_check
    $error("PTR_W must lie between 12 and 16");
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_add_ptr(input logic [15:0] w);
    is_add_ptr = (w[15:8] == `EXT_OP_ADD_PTR);
  endfunction

  function automatic logic is_call_via_working_register(input logic [15:0] w);
    is_call_via_working_register = (w == `EXT_OP_CALL_VIA_WORKING_REGISTER);
  endfunction

  function automatic logic is_move(input logic [15:0] w);
    is_move = (w[15:7] == `EXT_OP_MOVE);
  endfunction

  function automatic logic is_protected(input logic [11:0] a);
    is_protected = (a == PC_LOW_ADDR) || (a == STK_UP_ADDR) ||
                   (a == STK_HI_ADDR) || (a == STK_LO_ADDR);
  endfunction

  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a >= INDIRECT_LO) && (a <= INDIRECT_HI);
  endfunction

  // ****************************************
  // Phase enables
  // ****************************************
  logic q1;
  logic q2;
  logic q3;
  logic q4;

  quarter_phase_gen #(
    .PHASES (`EXT_QCOUNT)
  ) u_phase (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .o_q1  (q1),
    .o_q2  (q2),
    .o_q3  (q3),
    .o_q4  (q4)
  );

  // ****************************************
  // Instruction capture
  // ****************************************
  exec_state_t      state;
  logic [15:0]      cur;
  logic             ext_on;
  logic [11:0]      src_addr;
  logic             src_ind;
  logic [7:0]       move_data;
  logic [1:0]       sel;
  logic [PTR_W-1:0] sel_ptr;
  logic [PTR_W-1:0] next_ptr_val;
  logic [11:0]      next_src;
  logic             run_add;
  logic             run_ret;
  logic             run_call;
  logic             run_move;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur    <= `EXT_RST_WORD;
      ext_on <= 1'b0;
    end else if (q1) begin
      cur    <= i_instr_valid ? i_instr : `EXT_RST_WORD;
      ext_on <= i_ext_enable;
    end
  end

  assign sel     = cur[7:6];
  assign sel_ptr = (sel == 2'h0) ? i_ptr0 :
                   (sel == 2'h1) ? i_ptr1 : i_ptr2;
  assign next_ptr_val = sel_ptr + PTR_W'(cur[5:0]);
  assign next_src = i_ptr2[11:0] + 12'(cur[6:0]);

  // Decoded only while enabled and not inside a two-cycle op
  assign run_add  = (state == ST_IDLE) && ext_on && is_add_ptr(cur);
  assign run_ret  = run_add && (sel == `EXT_SEL_RETURN);
  assign run_call = (state == ST_IDLE) && ext_on && is_call_via_working_register(cur);
  assign run_move = (state == ST_IDLE) && ext_on && is_move(cur);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state  <= ST_IDLE;
      o_busy <= 1'b0;
    end else if (q4) begin
      case (state)
        ST_IDLE: begin
          if (run_ret || run_call) begin
            state  <= ST_NOP;
            o_busy <= 1'b1;
          end else if (run_move) begin
            state  <= ST_MOVE;
            o_busy <= 1'b1;
          end
        end
        ST_NOP: begin
          state  <= ST_IDLE;
          o_busy <= 1'b0;
        end
        ST_MOVE: begin
          state  <= ST_IDLE;
          o_busy <= 1'b0;
        end
        default: begin
          state  <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // Words for the standard decoder; extended ones reach the standard decoder only while i_ext_enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_std_pass <= 1'b0;
    end else if (q1) begin
      o_std_pass <= i_instr_valid && (state == ST_IDLE) &&
                    !(i_ext_enable && (is_add_ptr(i_instr) ||
                      is_call_via_working_register(i_instr) || is_move(i_instr)));
    end
  end

  // ****************************************
  // Pointer add and add-and-return
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ptr_we  <= 1'b0;
      o_ptr_sel <= 2'h0;
      o_ptr_val <= '0;
      o_pop     <= 1'b0;
    end else begin
      o_ptr_we <= 1'b0;
      o_pop    <= 1'b0;
      if (q4 && run_add) begin
        o_ptr_we  <= 1'b1;
        o_ptr_sel <= run_ret ? `EXT_SEL_FRAME : sel;
        o_ptr_val <= next_ptr_val;
        o_pop     <= run_ret;
      end
    end
  end

  // ****************************************
  // Return stack and program counter
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_push     <= 1'b0;
      o_push_val <= `EXT_RST_PC;
      o_pc_load  <= 1'b0;
      o_pc_val   <= `EXT_RST_PC;
    end else begin
      o_push    <= 1'b0;
      o_pc_load <= 1'b0;
      if (q3 && run_call) begin
        o_push     <= 1'b1;
        o_push_val <= i_pc + `EXT_RET_STEP;
      end
      if (q4 && run_call) begin
        o_pc_load <= 1'b1;
        o_pc_val  <= {i_pc_upper_latch, i_pc_high_latch,
                      i_working_register};
      end else if (q4 && run_ret) begin
        o_pc_load <= 1'b1;
        o_pc_val  <= i_tos;
      end
    end
  end

  // ****************************************
  // Indexed-to-file move
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_addr <= `EXT_RST_ADDR;
      src_ind  <= 1'b0;
      o_rd_en  <= 1'b0;
      o_rd_addr <= `EXT_RST_ADDR;
    end else begin
      o_rd_en <= 1'b0;
      if (q2 && run_move) begin
        src_addr <= next_src;
        src_ind  <= is_indirect(next_src);
      end
      if (q4 && run_move) begin
        o_rd_en   <= 1'b1;
        o_rd_addr <= src_addr;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      move_data <= 8'h00;
    end else if (q2 && state == ST_MOVE) begin
      move_data <= src_ind ? 8'h00 : i_rd_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wr_en        <= 1'b0;
      o_wr_addr      <= `EXT_RST_ADDR;
      o_wr_data      <= 8'h00;
      o_dest_blocked <= 1'b0;
    end else begin
      o_wr_en        <= 1'b0;
      o_dest_blocked <= 1'b0;
      if (q4 && state == ST_MOVE) begin
        if (cur[15:12] == `EXT_OP_SECOND && !is_protected(cur[11:0])) begin
          o_wr_en   <= 1'b1;
          o_wr_addr <= cur[11:0];
          o_wr_data <= move_data;
        end else begin
          o_dest_blocked <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic [PTR_W-1:0] exp_ptr;
  logic [11:0]      exp_src;
  assign exp_ptr = next_ptr_val;
  assign exp_src = next_src;

  ptr_add_a: assert property (
    (q4 && run_add && !run_ret) |=>
      o_ptr_we && !o_pop && o_ptr_val == $past(exp_ptr))
    else $error("pointer add result wrong");

  ret_frame_a: assert property (
    o_pop |-> o_ptr_we && o_ptr_sel == 2'h2)
    else $error("add-and-return not on frame pointer");

  ret_pc_a: assert property (
    (q4 && run_ret) |=> o_pop && o_pc_load && o_pc_val == $past(i_tos))
    else $error("add-and-return did not load stack top");

  ret_idle_a: assert property (
    o_pop |-> o_busy ##1
      (!o_ptr_we && !o_pc_load && !o_push && !o_wr_en) [*4])
    else $error("second cycle of add-and-return not idle");

  call_push_a: assert property (
    (q3 && run_call) |=>
      o_push && o_push_val == $past(i_pc) + 21'h0_0002 ##1 o_pc_load)
    else $error("register call push wrong");

  call_pc_a: assert property (
    (q4 && run_call) |=> o_pc_load && o_pc_val ==
      {$past(i_pc_upper_latch), $past(i_pc_high_latch), $past(i_working_register)})
    else $error("register call target wrong");

  call_nop_a: assert property (
    o_push |=> o_busy ##1 (!o_push && !o_pc_load && !o_rd_en) [*4])
    else $error("register call second cycle not idle");

  move_src_a: assert property (
    (q2 && run_move) ##2 q4 |=> o_rd_en && o_rd_addr == $past(exp_src, 3))
    else $error("move source address wrong");

  move_guard_a: assert property (
    o_wr_en |-> !is_protected(o_wr_addr))
    else $error("move wrote a protected register");

  move_zero_a: assert property (
    (o_wr_en && src_ind) |-> o_wr_data == 8'h00)
    else $error("indirect source did not read zero");

  ext_off_a: assert property (
    (!ext_on && state == ST_IDLE && q4) |=>
      !o_ptr_we && !o_pc_load && !o_rd_en && !o_busy)
    else $error("extended op ran while disabled");

  add_c: cover property (o_ptr_we && !o_pop);
  ret_c: cover property (o_pop);
  call_c: cover property (o_push ##1 o_pc_load);
  move_c: cover property (o_rd_en ##[1:8] o_wr_en);
  block_c: cover property (o_dest_blocked);

endmodule // extended_pointer_instruction_exec

// File: core/quarter_phase_gen.sv
// Quarter-phase enable generator for the instruction cycle
`include "ext_exec_defs.svh"

module quarter_phase_gen #(
  parameter int PHASES = `EXT_QCOUNT
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Phase enables
  output logic      o_q1,
  output logic      o_q2,
  output logic      o_q3,
  output logic      o_q4
);

  if (PHASES != 4) begin : g_phase_check
    $error("quarter_phase_gen serves exactly four phases");
  end

  logic [3:0] phase;

  // ****************************************
  // One-hot phase rotation
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= `EXT_RST_QPHASE;
    end else begin
      phase <= {phase[2:0], phase[3]};
    end
  end

  assign o_q1 = phase[0];
  assign o_q2 = phase[1];
  assign o_q3 = phase[2];
  assign o_q4 = phase[3];

endmodule // quarter_phase_gen

// File: dv/test_extended_pointer_instruction_exec.sv
// Self-checking bench for the extended pointer and call executor
module test_extended_pointer_instruction_exec
  import ext_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic        i_clk, i_rst, i_ext_enable, i_instr_valid;
  logic [15:0] i_instr;
  logic [20:0] i_pc, i_tos;
  logic [7:0]  i_working_register, i_pc_high_latch, i_rd_data, rdv;
  logic [4:0]  i_pc_upper_latch;
  logic [11:0] i_ptr0, i_ptr1, i_ptr2, o_ptr_val, o_rd_addr, o_wr_addr;
  logic        o_busy, o_std_pass, o_ptr_we, o_push, o_pop, o_pc_load;
  logic        o_rd_en, o_wr_en, o_dest_blocked;
  logic [1:0]  o_ptr_sel;
  logic [20:0] o_push_val, o_pc_val;
  logic [7:0]  o_wr_data;
  logic [8:1]  pw, ps, pp, pl, re, we, bl, bz, sp;
  int          err_count, cmp_count;

  extended_pointer_instruction_exec #(.PTR_W(12)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ext_enable(i_ext_enable),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_pc(i_pc),
    .i_tos(i_tos), .i_working_register(i_working_register), .i_pc_high_latch(i_pc_high_latch),
    .i_pc_upper_latch(i_pc_upper_latch), .i_ptr0(i_ptr0),
    .i_ptr1(i_ptr1), .i_ptr2(i_ptr2), .i_rd_data(i_rd_data),
    .o_busy(o_busy), .o_std_pass(o_std_pass), .o_ptr_we(o_ptr_we),
    .o_ptr_sel(o_ptr_sel), .o_ptr_val(o_ptr_val), .o_push(o_push),
    .o_push_val(o_push_val), .o_pop(o_pop), .o_pc_load(o_pc_load),
    .o_pc_val(o_pc_val), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr),
    .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_dest_blocked(o_dest_blocked)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_pat(input logic [8:1] got, input logic [8:1] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch pattern at %0t got %h expected %h",
               $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ptr_of(input int f);
    return (f == 0) ? i_ptr0 : (f == 1) ? i_ptr1 : i_ptr2;
  endfunction

  task automatic rnd;
    i_pc             = 21'($urandom);
    i_tos            = 21'($urandom);
    i_working_register           = 8'($urandom);
    i_pc_high_latch  = 8'($urandom);
    i_pc_upper_latch = 5'($urandom);
    i_ptr0           = 12'($urandom);
    i_ptr1           = 12'($urandom);
    i_ptr2           = 12'($urandom);
    rdv              = 8'($urandom);
  endtask

  task automatic tick;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // Present a word before its capture edge and record each clock after it
  task automatic run(input logic [15:0] w1, input logic [15:0] w2,
                     input int ticks, input logic vld = 1'b1);
    i_instr       = w1;
    i_instr_valid = vld;
    i_rd_data     = ~rdv;
    {pw, ps, pp, pl, re, we, bl, bz, sp} = '0;
    for (int t = 1; t <= ticks; t++) begin
      tick();
      pw[t] = o_ptr_we;
      ps[t] = o_push;
      pp[t] = o_pop;
      pl[t] = o_pc_load;
      re[t] = o_rd_en;
      we[t] = o_wr_en;
      bl[t] = o_dest_blocked;
      bz[t] = o_busy;
      sp[t] = o_std_pass;
      if (t == 4 && ticks == 8) begin
        i_instr   = w2;
        i_rd_data = rdv;
      end
    end
  endtask

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    #50us;
    err_count++;
    conclude();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin : main
    logic [5:0]  k;
    logic [6:0]  z;
    logic [11:0] src, dst;
    logic [15:0] w;
    logic [15:0] dis_w [4];
    void'($urandom(32'h923B_80C3));
    dis_w = '{16'hE845, 16'hE8C5, 16'h0014, 16'hEB05};
    err_count = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    i_ext_enable = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 16'h0000;
    rnd();
    i_rd_data = 8'h00;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    tick();
    for (int i = 0; i < 12; i++) begin
      rnd();
      k = (i < 3) ? 6'h3F : 6'($urandom);
      if (i == 0) i_ptr0 = 12'hFFF;
      run({8'hE8, 2'(i % 3), k}, 16'h0000, 4);
      chk_pat(pw, 8'h08);
      chk_val(o_ptr_sel, 21'(i % 3));
      chk_val(o_ptr_val, 12'(ptr_of(i % 3) + 12'(k)));
      chk_pat(pp | pl | bz | we, 8'h00);
      chk_val(sp[3], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      k = (i == 0) ? 6'h3F : 6'($urandom);
      run({8'hE8, 2'h3, k}, {8'hE8, 2'h0, 6'h01}, 8);
      chk_pat(pw, 8'h08);
      chk_pat(pp | pl, 8'h08);
      chk_pat(pp & pl, 8'h08);
      chk_val(o_ptr_sel, 21'h0_0002);
      chk_val(o_ptr_val, 12'(i_ptr2 + 12'(k)));
      chk_val(o_pc_val, i_tos);
      chk_pat(bz, 8'h78);
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      run(16'h0014, {8'hE8, 2'h1, 6'h05}, 8);
      chk_pat(ps, 8'h04);
      chk_val(o_push_val, i_pc + 21'h0_0002);
      chk_pat(pl, 8'h08);
      chk_val(o_pc_val, {i_pc_upper_latch, i_pc_high_latch, i_working_register});
      chk_pat(bz, 8'h78);
      chk_pat(pw | pp | re | we, 8'h00);
    end
    for (int i = 0; i < 10; i++) begin
      rnd();
      z = 7'($urandom);
      dst = 12'($urandom % 32'h0000_0FE0);
      if (i == 0) begin
        i_ptr2 = 12'hFFF;
        z = 7'h7F;
        dst = 12'h000;
      end
      if (i == 1) begin
        i_ptr2 = 12'hFD0;
        z = 7'h15;
        dst = 12'hFFF;
      end
      src = i_ptr2 + 12'(z);
      run({8'hEB, 1'b0, z}, {4'hF, dst}, 8);
      chk_pat(re, 8'h08);
      chk_val(o_rd_addr, src);
      chk_pat(we, 8'h80);
      chk_val(o_wr_addr, dst);
      chk_val(o_wr_data, (src >= 12'hFE0 && src <= 12'hFEF) ?
              8'h00 : rdv);
      chk_pat(bl | pw | ps | pl, 8'h00);
      chk_pat(bz, 8'h78);
    end
    for (int i = 0; i < 5; i++) begin
      rnd();
      z = 7'($urandom);
      w = (i < 4) ? {4'hF, 12'hFF0 + 12'(i)} : 16'h1234;
      run({8'hEB, 1'b0, z}, w, 8);
      chk_pat(we, 8'h00);
      chk_pat(bl, 8'h80);
    end
    for (int i = 0; i < 8; i++) begin
      rnd();
      w = 16'($urandom);
      w[15:12] = 4'h5;
      if (i == 0) w = 16'h0015;
      if (i == 1) w = 16'h0114;
      if (i == 2) w = 16'hE845;
      run(w, 16'h0000, 4, i != 2);
      chk_pat(pw | ps | pp | pl | re | we | bl | bz, 8'h00);
      chk_val(sp[3], 1'(i != 2));
    end
    i_ext_enable = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rnd();
      run(dis_w[i], 16'h0000, 4);
      chk_pat(pw | ps | pp | pl | re | we | bl | bz, 8'h00);
      chk_val(sp[3], 1'b1);
    end
    conclude();
  end
endmodule // test_extended_pointer_instruction_exec
